/* File: rtl/psm_power_saving_mode_control.sv */
// power saving mode controller: sleep entry, wake sources, stabilisation.
// assumes the core pulses sleepExec for its sleep instruction and all
// inputs are synchronous to clk_sys.
// Function
// - deep sleep exits only on hardware reset or external interrupt
// - reset wake restores registers, keeps ram; interrupt wake keeps all
// - non-reset wake: iflag 1 vectors, iflag 0 continues after sleep
// - deep sleep interrupt wake runs interval timer 00 to ff overflow
// - port data and direction keep driving pins in every sleep mode
// - timer wake: oscillator, 2048 prescaler, first timer only run
// - sleep with wake-timer select 1 enters timer wake mode
// - wake interval set by first timer compare value on prescaler
// - timer wake exits on reset, external interrupt or timer overflow
// - timer wake interrupt or overflow resumes with no stabilisation
// - rc watchdog sleep stops oscillator, rc clock runs watchdog
// - sleep with select bits 01 enters rc watchdog sleep
// - rc watchdog sleep exits on reset, external interrupt or watchdog timeout with iflag
// - watchdog wake with iflag: irq routine, or internal reset
// - rc watchdog interrupt wake runs interval timer to overflow
// - sleep with select bits 00 enters deep sleep
// - pending interrupt flag at sleep means no sleep happens
`timescale 1ns/1ps
`default_nettype none
module psm_power_saving_mode_control #(
    parameter int PRESCALE = 2048
) (
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              clkEn,
    // avalon-mm slave
    input  wire logic [5:0]        avsAddress,
    input  wire logic              avsRead,
    input  wire logic              avsWrite,
    input  wire logic [31:0]       avsWriteData,
    input  wire logic [3:0]        avsByteEnable,
    output var  logic [31:0]       avsReadData,
    output logic                   avsWaitRequest,
    // core and wake sources
    input  wire logic              sleepExec,
    input  wire logic              extIrq,
    input  wire logic              wdTimeout,
    input  wire logic [7:0]        portData,
    input  wire logic [7:0]        portDir,
    // outputs
    output var  psm_pkg::psm_wake_s wakeOut,
    output var  logic              cpuClkEn,
    output var  logic              mainOscEn,
    output var  logic              rcOscEn,
    output var  logic              prescalerEn,
    output var  logic              firstTimerEn,
    output var  logic [7:0]        portOut,
    output var  logic [7:0]        portOe_n
);

    // ========================================================================
    // state
    psm_pkg::psm_state_e stateReg, stateNext;
    psm_pkg::psm_mode_e  modeReg, modeNext;
    logic [7:0]  clkCtlReg, clkCtlNext;
    logic [7:0]  progStatReg, progStatNext;
    logic [15:0] irqFlagsReg, irqFlagsNext;
    logic [2:0]  ctrlReg, ctrlNext;
    logic [7:0]  tcmpReg, tcmpNext;
    logic [15:0] bitPreReg, bitPreNext;
    logic [15:0] preCntReg, preCntNext;
    logic [10:0] div2048Reg, div2048Next;
    logic [7:0]  t0CntReg, t0CntNext;
    logic [7:0]  bitCntReg, bitCntNext;
    logic        ackReg, ackNext;
    psm_pkg::psm_wake_s wakeReg, wakeNext;
    logic        byteWr, t0Tick, t0Ovf, bitTick, sleepGo;

    // bus decode: one cycle of wait, then acknowledge
    assign avsWaitRequest = (avsRead | avsWrite) & ~ackReg;
    assign byteWr  = avsWrite & ackReg & avsByteEnable[0];
    assign sleepGo = sleepExec | (byteWr & avsAddress == 6'(psm_pkg::ADDR_CTRL)
                     & avsWriteData[psm_pkg::CTRL_SLEEP]);
    assign t0Tick  = div2048Reg == 11'(PRESCALE - 1);
    assign t0Ovf   = t0Tick & (t0CntReg == tcmpReg) & ctrlReg[psm_pkg::CTRL_T0SRC];
    assign bitTick = preCntReg == bitPreReg;

    // ========================================================================
    // next-state logic
    always_comb begin
        stateNext    = stateReg;
        modeNext     = modeReg;
        clkCtlNext   = clkCtlReg;
        progStatNext = progStatReg;
        irqFlagsNext = irqFlagsReg;
        ctrlNext     = ctrlReg;
        tcmpNext     = tcmpReg;
        bitPreNext   = bitPreReg;
        preCntNext   = preCntReg;
        div2048Next  = div2048Reg;
        t0CntNext    = t0CntReg;
        bitCntNext   = bitCntReg;
        ackNext      = (avsRead | avsWrite) & ~ackReg;
        wakeNext     = '0;
        // whole-byte register writes; only lane 0 counts
        if (byteWr) begin
            case (avsAddress)
                6'(psm_pkg::ADDR_CLKCTL):   clkCtlNext = avsWriteData[7:0];
                6'(psm_pkg::ADDR_PROGSTAT): progStatNext = avsWriteData[7:0];
                6'(psm_pkg::ADDR_IRQFLAGS): irqFlagsNext = avsWriteData[15:0];
                6'(psm_pkg::ADDR_CTRL):     ctrlNext = avsWriteData[2:0];
                psm_pkg::ADDR_TCMP:         tcmpNext = avsWriteData[7:0];
                psm_pkg::ADDR_BITPRE:       bitPreNext = avsWriteData[15:0];
                default: ;
            endcase
        end
        // set wins over software clear of the request flags
        if (extIrq) begin
            irqFlagsNext[0] = 1'b1;
        end
        if (wdTimeout) begin
            irqFlagsNext[1] = 1'b1;
        end
        // wake timer prescaler and first timer run in run or timer mode
        if (stateReg == psm_pkg::PSM_RUN || modeReg == psm_pkg::MODE_TIMER) begin
            div2048Next = t0Tick ? 11'h000 : div2048Reg + 11'h001;
            if (t0Tick) begin
                t0CntNext = t0Ovf ? 8'h00 : t0CntReg + 8'h01;
            end
        end
        case (stateReg)
            psm_pkg::PSM_RUN: begin
                // pending request means the sleep is a no-op
                if (sleepGo && irqFlagsReg == 16'h0000 && !extIrq) begin
                    stateNext = psm_pkg::PSM_SLEEP;
                    if (clkCtlReg[psm_pkg::CK_WAKE_BIT]) begin
                        modeNext = psm_pkg::MODE_TIMER;
                    end else if (clkCtlReg[psm_pkg::CK_RCWD_BIT]) begin
                        modeNext = psm_pkg::MODE_RCWD;
                    end else begin
                        modeNext = psm_pkg::MODE_DEEP;
                    end
                    t0CntNext = 8'h00;
                end
            end
            psm_pkg::PSM_SLEEP: begin
                if (extIrq || (modeReg == psm_pkg::MODE_TIMER && t0Ovf)) begin
                    if (modeReg == psm_pkg::MODE_TIMER) begin
                        stateNext = psm_pkg::PSM_RESUME;
                    end else begin
                        stateNext  = psm_pkg::PSM_STAB;
                        bitCntNext = 8'h00;
                        preCntNext = 16'h0000;
                    end
                end else if (modeReg == psm_pkg::MODE_RCWD && wdTimeout
                             && progStatReg[psm_pkg::PS_IFLAG_BIT]) begin
                    // watchdog wake with interrupts on
                    if (clkCtlReg[psm_pkg::CK_WDRST_BIT]) begin
                        wakeNext.wdReset = 1'b1;
                        stateNext = psm_pkg::PSM_RUN;
                    end else if (ctrlReg[psm_pkg::CTRL_WDIE]) begin
                        stateNext  = psm_pkg::PSM_STAB;
                        bitCntNext = 8'h00;
                        preCntNext = 16'h0000;
                    end
                end
            end
            psm_pkg::PSM_STAB: begin
                // oscillator settle: interval timer 00 up to ff overflow
                preCntNext = bitTick ? 16'h0000 : preCntReg + 16'h0001;
                if (bitTick) begin
                    bitCntNext = bitCntReg + 8'h01;
                    if (bitCntReg == psm_pkg::BIT_TOP) begin
                        stateNext = psm_pkg::PSM_RESUME;
                    end
                end
            end
            psm_pkg::PSM_RESUME: begin
                stateNext = psm_pkg::PSM_RUN;
                if (irqFlagsReg[1] && modeReg == psm_pkg::MODE_RCWD
                    && !irqFlagsReg[0]) begin
                    wakeNext.wdIrq = progStatReg[psm_pkg::PS_IFLAG_BIT];
                end
                wakeNext.irqEntry   = progStatReg[psm_pkg::PS_IFLAG_BIT];
                wakeNext.continueOn = ~progStatReg[psm_pkg::PS_IFLAG_BIT];
            end
            default: stateNext = psm_pkg::PSM_RUN;
        endcase
    end

    // ========================================================================
    // registers; synchronous reset returns control registers (ram untouched)
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stateReg    <= psm_pkg::PSM_RUN;
            modeReg     <= psm_pkg::MODE_DEEP;
            clkCtlReg   <= psm_pkg::CLKCTL_RST;
            progStatReg <= psm_pkg::PS_RST;
            irqFlagsReg <= 16'h0000;
            ctrlReg     <= 3'h0;
            tcmpReg     <= psm_pkg::TCMP_RST;
            bitPreReg   <= psm_pkg::BITPRE_RST;
            preCntReg   <= 16'h0000;
            div2048Reg  <= 11'h000;
            t0CntReg    <= 8'h00;
            bitCntReg   <= 8'h00;
            ackReg      <= 1'b0;
            wakeReg     <= '0;
        end else if (clkEn) begin
            stateReg    <= stateNext;
            modeReg     <= modeNext;
            clkCtlReg   <= clkCtlNext;
            progStatReg <= progStatNext;
            irqFlagsReg <= irqFlagsNext;
            ctrlReg     <= ctrlNext;
            tcmpReg     <= tcmpNext;
            bitPreReg   <= bitPreNext;
            preCntReg   <= preCntNext;
            div2048Reg  <= div2048Next;
            t0CntReg    <= t0CntNext;
            bitCntReg   <= bitCntNext;
            ackReg      <= ackNext;
            wakeReg     <= wakeNext;
        end
    end

    // ========================================================================
    // clock and pin outputs; ports never float while asleep
    always_comb begin
        cpuClkEn     = stateReg == psm_pkg::PSM_RUN;
        mainOscEn    = stateReg != psm_pkg::PSM_SLEEP
                       || modeReg == psm_pkg::MODE_TIMER;
        rcOscEn      = stateReg == psm_pkg::PSM_SLEEP
                       && modeReg == psm_pkg::MODE_RCWD;
        prescalerEn  = mainOscEn;
        firstTimerEn = stateReg == psm_pkg::PSM_RUN
                       || modeReg == psm_pkg::MODE_TIMER;
        portOut      = portData;
        portOe_n     = ~portDir;
        wakeOut      = wakeReg;
    end

    // read data: status word carries state, mode and counters
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            avsReadData <= 32'h0000_0000;
        end else if (clkEn) begin
            case (avsAddress)
                6'(psm_pkg::ADDR_CLKCTL):   avsReadData <= {24'h0, clkCtlReg};
                6'(psm_pkg::ADDR_PROGSTAT): avsReadData <= {24'h0, progStatReg};
                6'(psm_pkg::ADDR_IRQFLAGS): avsReadData <= {16'h0, irqFlagsReg};
                6'(psm_pkg::ADDR_CTRL):     avsReadData <= {29'h0, ctrlReg};
                psm_pkg::ADDR_STAT: avsReadData <= {8'h0, t0CntReg, bitCntReg,
                                           3'h0, modeReg, stateReg};
                psm_pkg::ADDR_TCMP:   avsReadData <= {24'h0, tcmpReg};
                psm_pkg::ADDR_BITPRE: avsReadData <= {16'h0, bitPreReg};
                default:              avsReadData <= 32'h0000_0000;
            endcase
        end
    end

    // ========================================================================
    // checks
    AST_DEEP_WAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clkEn && stateReg == psm_pkg::PSM_SLEEP && modeReg == psm_pkg::MODE_DEEP
        && !extIrq |=> stateReg == psm_pkg::PSM_SLEEP || !$past(clkEn))
        else $error("deep sleep left without interrupt");
    AST_NO_SLEEP_PENDING: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clkEn && stateReg == psm_pkg::PSM_RUN && irqFlagsReg != 16'h0
        |=> stateReg == psm_pkg::PSM_RUN)
        else $error("slept with pending request");
    AST_TIMER_ENTRY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clkEn && stateNext == psm_pkg::PSM_SLEEP && stateReg == psm_pkg::PSM_RUN
        && clkCtlReg[psm_pkg::CK_WAKE_BIT] |=> modeReg == psm_pkg::MODE_TIMER)
        else $error("timer wake mode not entered");
    AST_RCWD_ENTRY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clkEn && stateNext == psm_pkg::PSM_SLEEP && stateReg == psm_pkg::PSM_RUN
        && clkCtlReg[6:5] == 2'b01 |=> modeReg == psm_pkg::MODE_RCWD)
        else $error("rc watchdog sleep not entered");
    AST_TIMER_NOSTAB: assert property (@(posedge clk_sys) disable iff (!reset_n)
        modeReg == psm_pkg::MODE_TIMER |-> stateReg != psm_pkg::PSM_STAB)
        else $error("timer wake stabilised");
    AST_CLK_GATED: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stateReg != psm_pkg::PSM_RUN |-> !cpuClkEn)
        else $error("cpu clock during sleep");
    AST_OSC: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rcOscEn |-> !mainOscEn)
        else $error("main oscillator running in rc sleep");
    AST_IFLAG: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clkEn && stateReg == psm_pkg::PSM_RESUME
        |=> wakeReg.irqEntry == $past(progStatReg[psm_pkg::PS_IFLAG_BIT])
            && wakeReg.continueOn != wakeReg.irqEntry)
        else $error("wrong resume path");
    COV_DEEP: cover property (@(posedge clk_sys)
        stateReg == psm_pkg::PSM_STAB && modeReg == psm_pkg::MODE_DEEP);
    COV_TIMER: cover property (@(posedge clk_sys)
        stateReg == psm_pkg::PSM_RESUME && modeReg == psm_pkg::MODE_TIMER);
    COV_WDRST: cover property (@(posedge clk_sys) wakeReg.wdReset);

endmodule : psm_power_saving_mode_control
`default_nettype wire

/* File: rtl/psm_pkg.sv */
// power saving mode controller package: register map, field positions,
// reset values and timing constants.
// assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package psm_pkg;

    // ========================================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [3:0] ADDR_CLKCTL   = 4'h0; // clock_control_register
    localparam logic [3:0] ADDR_PROGSTAT = 4'h4; // program_status_word
    localparam logic [3:0] ADDR_IRQFLAGS = 4'h8; // irq_request_flags high/low
    localparam logic [3:0] ADDR_CTRL     = 4'hc; // sleep command, enables
    localparam logic [3:0] ADDR_STATUS   = 4'h0; // status shares slot below
    localparam logic [3:0] ADDR_TIMER    = 4'h0; // unused alias guard
    localparam logic [5:0] ADDR_STAT     = 6'h10;
    localparam logic [5:0] ADDR_TCMP     = 6'h14; // first_timer_compare_value
    localparam logic [5:0] ADDR_BITPRE   = 6'h18; // interval timer prescale

    // ========================================================================
    // field positions
    localparam int CK_WAKE_BIT   = 6; // wake-timer select
    localparam int CK_RCWD_BIT   = 5; // rc_watchdog_select
    localparam int CK_WDRST_BIT  = 4; // watchdog_reset_select
    localparam int PS_IFLAG_BIT  = 2; // interrupt master flag
    localparam int CTRL_SLEEP    = 0; // write 1: execute sleep instruction
    localparam int CTRL_WDIE     = 1; // watchdog_irq_enable
    localparam int CTRL_T0SRC    = 2; // first timer clocked by prescaler

    // ========================================================================
    // reset values
    localparam logic [7:0]  CLKCTL_RST = 8'h00;
    localparam logic [7:0]  PS_RST     = 8'h00;
    localparam logic [7:0]  TCMP_RST   = 8'hff;
    localparam logic [15:0] BITPRE_RST = 16'h0000;

    // ========================================================================
    // timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int PRESCALE_RATIO  = 2048; // wake timer prescaler
    localparam logic [7:0] BIT_TOP = 8'hff; // interval timer counts 00..ff

    // ========================================================================
    // controller states, gray along idle->sleep->stabilise->resume
    typedef enum logic [2:0] {
        PSM_RUN    = 3'b000,
        PSM_SLEEP  = 3'b001,
        PSM_STAB   = 3'b011,
        PSM_RESUME = 3'b010
    } psm_state_e;

    typedef enum logic [1:0] {
        MODE_DEEP  = 2'h0,
        MODE_TIMER = 2'h1,
        MODE_RCWD  = 2'h2
    } psm_mode_e;

    // wake outcome to the processor core
    typedef struct packed {
        logic irqEntry;   // vector to interrupt routine
        logic continueOn; // resume at instruction after sleep
        logic wdIrq;      // watchdog interrupt routine
        logic wdReset;    // internal reset request
    } psm_wake_s;

endpackage : psm_pkg

/* File: tb/testbench.sv */
// testbench for the power saving mode controller: drives its ports directly
// assumes the design package is compiled first; prescaler lowered to 4
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ========================================================================
    // stimulus and observed signals
    logic                clk_sys = 1'b0;
    logic                reset_n = 1'b0;
    logic [5:0]          avsAddress = 6'h00;
    logic                avsRead = 1'b0;
    logic                avsWrite = 1'b0;
    logic [31:0]         avsWriteData = 32'h0;
    logic [31:0]         avsReadData;
    logic                avsWaitRequest;
    logic                sleepExec = 1'b0;
    logic                extIrq = 1'b0;
    logic                wdTimeout = 1'b0;
    psm_pkg::psm_wake_s  wakeOut;
    logic                cpuClkEn, mainOscEn, rcOscEn, prescalerEn;
    logic                firstTimerEn;
    logic [7:0]          portOut, portOe_n;
    int                  miscompares = 0;
    int                  nCompared = 0;
    localparam int P_SLEEP = 0; // pulse selectors
    localparam int P_IRQ   = 1;
    localparam int P_WD    = 2;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    psm_power_saving_mode_control #(.PRESCALE(4)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(1'b1),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(4'hf),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .sleepExec(sleepExec), .extIrq(extIrq), .wdTimeout(wdTimeout),
        .portData(8'ha5), .portDir(8'h3c), .wakeOut(wakeOut),
        .cpuClkEn(cpuClkEn), .mainOscEn(mainOscEn), .rcOscEn(rcOscEn),
        .prescalerEn(prescalerEn), .firstTimerEn(firstTimerEn),
        .portOut(portOut), .portOe_n(portOe_n));

    // ========================================================================
    // reporting
    task automatic tallyAndFinish;
        $display("compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tallyAndFinish

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // ========================================================================
    // avalon master: hold request until waitrequest samples low
    task automatic busXfer(input logic wr, input logic [5:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avsAddress <= a;
        avsWriteData <= d;
        if (wr) avsWrite <= 1'b1;
        else avsRead <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (avsWaitRequest === 1'b0) break;
        end
        if (n == 50) begin
            miscompares++;
            tallyAndFinish();
        end
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : busXfer

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        busXfer(1'b1, a, d, q);
    endtask : wr

    task automatic rdChk(input string what, input logic [5:0] a,
                         input logic [31:0] exp);
        logic [31:0] q;
        busXfer(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask : rdChk

    // ========================================================================
    // sleep helpers: flags cleared last, since a pending flag blocks sleep
    task automatic setup(input logic [7:0] ck, input logic [7:0] ps,
                         input logic [7:0] ctl);
        wr({2'b00, psm_pkg::ADDR_CLKCTL}, {24'h0, ck});
        wr({2'b00, psm_pkg::ADDR_PROGSTAT}, {24'h0, ps});
        wr({2'b00, psm_pkg::ADDR_CTRL}, {24'h0, ctl});
        wr(psm_pkg::ADDR_BITPRE, 32'h0);
        wr({2'b00, psm_pkg::ADDR_IRQFLAGS}, 32'h0);
    endtask : setup

    // one-cycle strobe; returns just after the taking edge so that a
    // one-cycle wake pulse launched there is still ahead of the caller
    task automatic pulse(input int which);
        @(posedge clk_sys);
        case (which)
            P_SLEEP: sleepExec <= 1'b1;
            P_IRQ:   extIrq <= 1'b1;
            default: wdTimeout <= 1'b1;
        endcase
        @(posedge clk_sys);
        sleepExec <= 1'b0;
        extIrq    <= 1'b0;
        wdTimeout <= 1'b0;
        #1;
    endtask : pulse

    // waits for the one-cycle wake pulse, counting cycles
    task automatic waitWake(input int lim, output psm_pkg::psm_wake_s w,
                            output int n);
        w = '0;
        for (n = 0; n < lim; n++) begin
            @(posedge clk_sys);
            if (wakeOut !== 4'h0) begin
                w = wakeOut;
                break;
            end
        end
        if (n == lim) begin
            miscompares++;
            tallyAndFinish();
        end
    endtask : waitWake

    // ========================================================================
    // scenarios
    task automatic tReset;
        rdChk("clkctl", {2'b00, psm_pkg::ADDR_CLKCTL}, 32'h00);
        rdChk("tcmp", psm_pkg::ADDR_TCMP, 32'hff);
        rdChk("unmapped", 6'h1c, 32'h0);
        check("cpuclk", {31'h0, cpuClkEn}, 32'h1);
    endtask : tReset

    task automatic tDeep;
        psm_pkg::psm_wake_s w;
        int n;
        setup(8'h0e, 8'h04, 8'h00);
        pulse(P_SLEEP);
        check("deep osc", {mainOscEn, cpuClkEn, rcOscEn}, 32'h0);
        check("port out", {portOut, portOe_n}, {16'h0, 8'ha5, 8'hc3});
        pulse(P_WD);
        repeat (20) @(posedge clk_sys);
        check("deep hold", {31'h0, cpuClkEn}, 32'h0);
        pulse(P_IRQ);
        repeat (100) @(posedge clk_sys);
        #1 check("stab clk", {31'h0, cpuClkEn}, 32'h0);
        waitWake(400, w, n);
        check("deep wake", w, 4'b1000);
        // cycles from the waking edge: 256 interval ticks plus resume
        check("stab long", {31'h0, (n + 101) >= 256 && (n + 101) <= 264},
              32'h1);
        rdChk("kept ck", {2'b00, psm_pkg::ADDR_CLKCTL}, 32'h0e);
    endtask : tDeep

    task automatic tTimer;
        psm_pkg::psm_wake_s w;
        int n;
        wr(psm_pkg::ADDR_TCMP, 32'h3);
        setup(8'h60, 8'h00, 8'h04);
        pulse(P_SLEEP);
        check("tw ens", {mainOscEn, prescalerEn, firstTimerEn, rcOscEn,
                         cpuClkEn}, 32'b11100);
        waitWake(200, w, n);
        check("tw wake", w, 4'b0100);
        check("tw ival", {31'h0, n >= 8 && n <= 30}, 32'h1);
        rdChk("tw keep", psm_pkg::ADDR_TCMP, 32'h3);
    endtask : tTimer

    task automatic tRcwd;
        psm_pkg::psm_wake_s w;
        int n;
        setup(8'h30, 8'h04, 8'h00);
        pulse(P_SLEEP);
        check("rc ens", {mainOscEn, rcOscEn, cpuClkEn}, 32'b010);
        pulse(P_WD);
        waitWake(40, w, n);
        check("wd reset", w, 4'b0001);
        check("wd fast", {31'h0, n <= 2}, 32'h1);
        setup(8'h20, 8'h04, 8'h02);
        pulse(P_SLEEP);
        pulse(P_WD);
        waitWake(400, w, n);
        // watchdog routine is entered through normal interrupt entry
        check("wd irq", w, 4'b1010);
        setup(8'h20, 8'h04, 8'h00);
        pulse(P_SLEEP);
        pulse(P_IRQ);
        waitWake(400, w, n);
        check("rc ext", w, 4'b1000);
        check("rc stab", {31'h0, n >= 250}, 32'h1);
    endtask : tRcwd

    task automatic tPending;
        psm_pkg::psm_wake_s w;
        int n;
        logic [31:0] q;
        setup(8'h00, 8'h00, 8'h00);
        pulse(P_IRQ);
        pulse(P_SLEEP);
        check("no sleep", {31'h0, cpuClkEn}, 32'h1);
        busXfer(1'b0, psm_pkg::ADDR_STAT, 32'h0, q);
        check("state", {29'h0, q[2:0]}, {29'h0, psm_pkg::PSM_RUN});
        // sleep by control write once the flags are clear
        wr({2'b00, psm_pkg::ADDR_IRQFLAGS}, 32'h0);
        wr({2'b00, psm_pkg::ADDR_CTRL}, 32'h1);
        #1 check("ctl sleep", {31'h0, cpuClkEn}, 32'h0);
        pulse(P_IRQ);
        waitWake(400, w, n);
        check("ctl wake", w, 4'b0100);
    endtask : tPending

    task automatic tResetWake;
        setup(8'h1e, 8'h04, 8'h00);
        pulse(P_SLEEP);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 check("rst clk", {mainOscEn, cpuClkEn}, 32'h3);
        rdChk("rst ck", {2'b00, psm_pkg::ADDR_CLKCTL}, 32'h0);
        rdChk("rst progstat", {2'b00, psm_pkg::ADDR_PROGSTAT}, 32'h0);
    endtask : tResetWake

    // ========================================================================
    // main sequence with a global watchdog on the run
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        tReset();
        tDeep();
        tTimer();
        tRcwd();
        tPending();
        tResetWake();
        tallyAndFinish();
    end

    initial begin
        #4000000;
        miscompares++;
        tallyAndFinish();
    end
endmodule : testbench
`default_nettype wire
